// ==== fsrg_gate.sv ====
// fsrg_gate.sv: command gating, suspend and resume for a serial nor flash, apb register file
// assumes a host that drives cs_n, sck and io lines; pins are asynchronous to pclk
`timescale 1ns/1ps
`default_nettype none
`include "fsrg_params.svh"

module fsrg_gate
	import fsrg_pkg::*;
#(
	parameter logic [7:0] SUSPEND_OPCODE = 8'hB0,
	parameter int         PROG_CYCLES    = 2000,
	parameter int         ERASE_CYCLES   = 4000
)
(
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// flash link
	input  wire logic        cs_n,
	input  wire logic        sck,
	input  wire logic [3:0]  io_in,
	// to device core
	output logic             cmd_valid,
	output logic      [7:0]  cmd_opcode,
	output logic             write_in_progress,
	output logic             program_suspended_flag,
	output logic             erase_suspended_flag,
	output logic             irq
);

	function automatic logic cmd_permitted(input logic [7:0] op, input logic ps,
		input logic es, input logic qe);
		logic ok;
		ok = 1'b0;
		if (!(ps | es))
			ok = 1'b1;
		else
		begin
			case (op)
				`FSRG_OP_FAST_READ, `FSRG_OP_FAST_READ4, `FSRG_OP_READ4,
				`FSRG_OP_DUAL_OUT, `FSRG_OP_DUAL_OUT4,
				`FSRG_OP_DUAL_IO, `FSRG_OP_DUAL_IO4: ok = 1'b1;
				`FSRG_OP_QUAD_OUT, `FSRG_OP_QUAD_OUT4, `FSRG_OP_QUAD_IO,
				`FSRG_OP_QUAD_IO4, `FSRG_OP_DDR_QUAD: ok = qe;
				`FSRG_OP_LOCK_RD, `FSRG_OP_LOCK_RD4, `FSRG_OP_LOCK_SET,
				`FSRG_OP_LOCK_SET4, `FSRG_OP_LOCK_CLR, `FSRG_OP_LOCK_CLR4: ok = 1'b1;
				`FSRG_OP_MODE_RST: ok = 1'b1;
				`FSRG_OP_SEC_PROG: ok = es & ~ps;
				`FSRG_OP_SEC_READ: ok = 1'b1;
				`FSRG_OP_WR_EN, `FSRG_OP_WR_DIS, `FSRG_OP_CLR_STAT,
				`FSRG_OP_RESUME, `FSRG_OP_RST_EN, `FSRG_OP_RST: ok = 1'b1;
				`FSRG_OP_PROG, `FSRG_OP_PROG4, `FSRG_OP_QPROG,
				`FSRG_OP_QPROG4: ok = es & ~ps;
				default: ok = (op == SUSPEND_OPCODE);
			endcase
		end
		return ok;
	endfunction

	function automatic logic is_program(input logic [7:0] op);
		return (op == `FSRG_OP_PROG) || (op == `FSRG_OP_PROG4) ||
			(op == `FSRG_OP_QPROG) || (op == `FSRG_OP_QPROG4) || (op == `FSRG_OP_SEC_PROG);
	endfunction

	function automatic logic is_read(input logic [7:0] op);
		return (op == `FSRG_OP_FAST_READ) || (op == `FSRG_OP_FAST_READ4) ||
			(op == `FSRG_OP_READ4) || (op == `FSRG_OP_DUAL_OUT) ||
			(op == `FSRG_OP_DUAL_OUT4) || (op == `FSRG_OP_DUAL_IO) ||
			(op == `FSRG_OP_DUAL_IO4) || (op == `FSRG_OP_QUAD_OUT) ||
			(op == `FSRG_OP_QUAD_OUT4) || (op == `FSRG_OP_QUAD_IO) ||
			(op == `FSRG_OP_QUAD_IO4) || (op == `FSRG_OP_DDR_QUAD);
	endfunction

	localparam logic [15:0] PROG_LOAD  = 16'(PROG_CYCLES);
	localparam logic [15:0] ERASE_LOAD = 16'(ERASE_CYCLES);

	// pin synchronisers: {io, sck, cs_n}
	logic [5:0]  sync1_reg;
	logic [5:0]  sync2_reg;
	logic [5:0]  sync3_reg;
	logic [5:0]  pin_reg;
	logic [5:0]  pin_d_reg;
	logic [5:0]  pin_next;
	// frame
	logic [5:0]  bit_cnt_reg;
	logic [31:0] shift_reg;
	logic [7:0]  frame_op_reg;
	logic        gather_reg;
	logic        pend_prog_reg;
	logic        pend_erase_reg;
	logic [23:0] pend_addr_reg;
	// operation state
	fsrg_state_type state_reg;
	fsrg_state_type state_next;
	logic [15:0] prog_cnt_reg;
	logic [15:0] erase_cnt_reg;
	logic [11:0] erase_sector_reg;
	logic [15:0] prog_page_reg;
	logic        wel_reg;
	logic        perr_reg;
	// registers
	logic [1:0]  ctrl_reg;
	logic [`FSRG_EV_WIDTH-1:0] event_reg;
	logic [`FSRG_EV_WIDTH-1:0] mask_reg;
	logic [`FSRG_EV_WIDTH-1:0] event_set;
	logic [8:0]  last_cmd_reg;
	logic        cmd_valid_reg;

	// a change counts only when stages two and three agree
	assign pin_next = (~(sync2_reg ^ sync3_reg) & sync3_reg) | ((sync2_reg ^ sync3_reg) & pin_reg);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sync1_reg <= 6'h01;
			sync2_reg <= 6'h01;
			sync3_reg <= 6'h01;
			pin_reg   <= 6'h01;
			pin_d_reg <= 6'h01;
		end
		else
		begin
			sync1_reg <= {io_in, sck, cs_n};
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
			pin_reg   <= pin_next;
			pin_d_reg <= pin_reg;
		end
	end

	wire       cs_active  = ~pin_reg[0];
	wire       cs_rise    = pin_reg[0] & ~pin_d_reg[0];
	wire       sck_rise   = pin_reg[1] & ~pin_d_reg[1] & cs_active;
	wire [3:0] io_now     = pin_reg[5:2];
	wire       four_line  = ctrl_reg[`FSRG_CTRL_FOUR];
	wire       qe         = ctrl_reg[`FSRG_CTRL_QE];
	wire       ps         = (state_reg == FSRG_PSUSP) || (state_reg == FSRG_NPSUSP);
	wire       es         = (state_reg == FSRG_ESUSP) || (state_reg == FSRG_NPROG) ||
		(state_reg == FSRG_NPSUSP);

	// four line mode shifts a nibble per edge, opcode included
	wire [31:0] shift_next = four_line ? {shift_reg[27:0], io_now} : {shift_reg[30:0], io_now[0]};
	wire [5:0]  cnt_next   = bit_cnt_reg + (four_line ? 6'h04 : 6'h01);
	wire        counting   = sck_rise && (bit_cnt_reg < `FSRG_ADDR_END);
	wire        op_done    = counting && (cnt_next == `FSRG_OPCODE_BITS);
	wire        addr_done  = counting && gather_reg && (cnt_next == `FSRG_ADDR_END);
	wire [7:0]  op_now     = shift_next[7:0];
	wire        op_ok      = op_done && cmd_permitted(op_now, ps, es, qe);
	wire        op_refused = op_done && !op_ok;
	wire        is_resume  = op_ok && (op_now == `FSRG_OP_RESUME);
	wire        is_suspend = op_ok && (op_now == SUSPEND_OPCODE);
	wire        any_susp   = ps | es;
	wire        prog_run   = (state_reg == FSRG_PROG) || (state_reg == FSRG_NPROG);
	wire        erase_run  = state_reg == FSRG_ERASE;
	wire        prog_fin   = prog_run && (prog_cnt_reg == 16'h0001);
	wire        erase_fin  = erase_run && (erase_cnt_reg == 16'h0001);
	wire [23:0] addr_now   = shift_next[23:0];
	// reads hitting the frozen sector or page return undefined data
	wire        undef_rd   = addr_done && is_read(frame_op_reg) &&
		((es && (addr_now[23:12] == erase_sector_reg)) ||
		(ps && (addr_now[23:8] == prog_page_reg)));
	wire        launch     = cs_rise && wel_reg && (pend_prog_reg || pend_erase_reg);
	wire        prog_ok_st = (state_reg == FSRG_IDLE) || (state_reg == FSRG_ESUSP);
	wire        perr_hit   = launch && pend_prog_reg && (state_reg == FSRG_ESUSP) &&
		(pend_addr_reg[23:12] == erase_sector_reg);
	wire        prog_start = launch && pend_prog_reg && prog_ok_st && !perr_hit;
	wire        erase_start = launch && pend_erase_reg && (state_reg == FSRG_IDLE);

	always_comb
	begin
		state_next = state_reg;
		if (prog_fin)
			state_next = (state_reg == FSRG_NPROG) ? FSRG_ESUSP : FSRG_IDLE;
		else if (erase_fin)
			state_next = FSRG_IDLE;
		else if (is_suspend)
		begin
			case (state_reg)
				FSRG_PROG:  state_next = FSRG_PSUSP;
				FSRG_ERASE: state_next = FSRG_ESUSP;
				FSRG_NPROG: state_next = FSRG_NPSUSP;
				default:    state_next = state_reg;
			endcase
		end
		else if (is_resume)
		begin
			// only resume leaves FSRG_PSUSP or FSRG_NPSUSP, a program start also leaves FSRG_ESUSP; wip rises with it
			case (state_reg)
				FSRG_PSUSP:  state_next = FSRG_PROG;
				FSRG_ESUSP:  state_next = FSRG_ERASE;
				FSRG_NPSUSP: state_next = FSRG_NPROG;
				default:     state_next = state_reg;
			endcase
		end
		else if (prog_start)
			state_next = (state_reg == FSRG_ESUSP) ? FSRG_NPROG : FSRG_PROG;
		else if (erase_start)
			state_next = FSRG_ERASE;
		else
			state_next = state_reg;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			state_reg <= FSRG_IDLE;
		else
			state_reg <= state_next;
	end

	// frame capture; bit count, gather and pending flags cleared at chip select release
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			bit_cnt_reg    <= 6'h00;
			shift_reg      <= 32'h0000_0000;
			frame_op_reg   <= 8'h00;
			gather_reg     <= 1'b0;
			pend_prog_reg  <= 1'b0;
			pend_erase_reg <= 1'b0;
			pend_addr_reg  <= 24'h00_0000;
		end
		else if (!cs_active)
		begin
			bit_cnt_reg    <= 6'h00;
			gather_reg     <= 1'b0;
			pend_prog_reg  <= 1'b0;
			pend_erase_reg <= 1'b0;
		end
		else if (counting)
		begin
			bit_cnt_reg <= cnt_next;
			shift_reg   <= shift_next;
			if (op_done)
			begin
				frame_op_reg <= op_now;
				gather_reg   <= op_ok && (is_read(op_now) || is_program(op_now) ||
					(op_now == `FSRG_OP_ERASE));
			end
			if (addr_done)
			begin
				gather_reg     <= 1'b0;
				pend_addr_reg  <= addr_now;
				pend_prog_reg  <= is_program(frame_op_reg);
				pend_erase_reg <= frame_op_reg == `FSRG_OP_ERASE;
			end
		end
	end

	// embedded operation timers; a suspended one simply stops counting
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prog_cnt_reg     <= 16'h0000;
			erase_cnt_reg    <= 16'h0000;
			erase_sector_reg <= 12'h000;
			prog_page_reg    <= 16'h0000;
		end
		else
		begin
			if (prog_start)
			begin
				prog_cnt_reg  <= PROG_LOAD;
				prog_page_reg <= pend_addr_reg[23:8];
			end
			else if (prog_run && !is_suspend)
				prog_cnt_reg <= prog_cnt_reg - 16'h0001;
			if (erase_start)
			begin
				erase_cnt_reg    <= ERASE_LOAD;
				erase_sector_reg <= pend_addr_reg[23:12];
			end
			else if (erase_run && !is_suspend)
				erase_cnt_reg <= erase_cnt_reg - 16'h0001;
		end
	end

	// write enable latch and program error flag
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			wel_reg  <= 1'b0;
			perr_reg <= 1'b0;
		end
		else
		begin
			if (launch)
				wel_reg <= 1'b0;
			else if (op_ok && (op_now == `FSRG_OP_WR_EN))
				wel_reg <= 1'b1;
			else if (op_ok && (op_now == `FSRG_OP_WR_DIS))
				wel_reg <= 1'b0;
			if (perr_hit)
				perr_reg <= 1'b1;
			else if (op_ok && (op_now == `FSRG_OP_CLR_STAT))
				perr_reg <= 1'b0;
		end
	end

	// accepted opcode handed to the core for one cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cmd_valid_reg <= 1'b0;
			last_cmd_reg  <= 9'h000;
		end
		else
		begin
			cmd_valid_reg <= op_ok;
			if (op_done)
				last_cmd_reg <= {op_ok, op_now};
		end
	end

	// apb: zero wait states, read data captured in the setup phase
	wire setup_ph = psel && !penable;
	wire access   = psel && penable;
	wire hit_ctrl = paddr == `FSRG_REG_CTRL;
	wire hit_st1  = paddr == `FSRG_REG_STATUS1;
	wire hit_st2  = paddr == `FSRG_REG_STATUS2;
	wire hit_ev   = paddr == `FSRG_REG_EVENT;
	wire hit_mask = paddr == `FSRG_REG_MASK;
	wire hit_last = paddr == `FSRG_REG_LAST_CMD;
	wire mapped   = hit_ctrl | hit_st1 | hit_st2 | hit_ev | hit_mask | hit_last;
	wire wr_ctrl  = access && pwrite && hit_ctrl && !any_susp;
	wire wr_ev    = access && pwrite && hit_ev;
	wire wr_mask  = access && pwrite && hit_mask;

	wire [31:0] st1_word = {30'h0, wel_reg, prog_run | erase_run};
	wire [31:0] st2_word = {26'h0, perr_reg, 3'h0, es, ps};
	wire [31:0] rd_word  = hit_ctrl ? {30'h0, ctrl_reg} :
		hit_st1  ? st1_word :
		hit_st2  ? st2_word :
		hit_ev   ? {27'h0, event_reg} :
		hit_mask ? {27'h0, mask_reg} :
		hit_last ? {23'h0, last_cmd_reg} : 32'h0000_0000;

	assign event_set = {undef_rd, is_resume && !any_susp, perr_hit, op_refused,
		prog_fin | erase_fin};

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata    <= 32'h0000_0000;
			ctrl_reg  <= 2'h0;
			event_reg <= 5'h00;
			mask_reg  <= 5'h00;
		end
		else
		begin
			if (setup_ph)
				prdata <= rd_word;
			// quad enable only changes outside suspend, so set it before programming
			if (wr_ctrl)
				ctrl_reg <= pwdata[1:0];
			if (wr_mask)
				mask_reg <= pwdata[`FSRG_EV_WIDTH-1:0];
			// new events win over a write-one clear in the same cycle
			event_reg <= (event_reg & ~(wr_ev ? pwdata[`FSRG_EV_WIDTH-1:0] : 5'h00)) | event_set;
		end
	end

	assign pready                 = 1'b1;
	assign pslverr                = access && !mapped;
	assign irq                    = |(event_reg & mask_reg);
	assign cmd_valid              = cmd_valid_reg;
	assign cmd_opcode             = last_cmd_reg[7:0];
	assign write_in_progress      = prog_run | erase_run;
	assign program_suspended_flag = ps;
	assign erase_suspended_flag   = es;

endmodule
`default_nettype wire

// ==== fsrg_params.svh ====
// fsrg_params.svh: opcodes, register map and field positions of the suspend/resume gate
// assumes inclusion by fsrg_pkg.sv and fsrg_gate.sv, and also by the checker and the bench
`ifndef FSRG_PARAMS_SVH
`define FSRG_PARAMS_SVH

// array reads
`define FSRG_OP_FAST_READ    8'h0B
`define FSRG_OP_FAST_READ4   8'h0C
`define FSRG_OP_READ4        8'h13
`define FSRG_OP_DUAL_OUT     8'h3B
`define FSRG_OP_DUAL_OUT4    8'h3C
`define FSRG_OP_DUAL_IO      8'hBB
`define FSRG_OP_DUAL_IO4     8'hBC
`define FSRG_OP_QUAD_OUT     8'h6B
`define FSRG_OP_QUAD_OUT4    8'h6C
`define FSRG_OP_QUAD_IO      8'hEB
`define FSRG_OP_QUAD_IO4     8'hEC
`define FSRG_OP_DDR_QUAD     8'hED
// block lock
`define FSRG_OP_LOCK_RD      8'h3D
`define FSRG_OP_LOCK_RD4     8'hE0
`define FSRG_OP_LOCK_SET     8'h36
`define FSRG_OP_LOCK_SET4    8'hE1
`define FSRG_OP_LOCK_CLR     8'h39
`define FSRG_OP_LOCK_CLR4    8'hE2
// misc
`define FSRG_OP_MODE_RST     8'hFF
`define FSRG_OP_SEC_PROG     8'h42
`define FSRG_OP_SEC_READ     8'h48
`define FSRG_OP_WR_EN        8'h06
`define FSRG_OP_WR_DIS       8'h04
`define FSRG_OP_CLR_STAT     8'h30
`define FSRG_OP_RESUME       8'h7A
`define FSRG_OP_RST_EN       8'h66
`define FSRG_OP_RST          8'h99
`define FSRG_OP_PROG         8'h02
`define FSRG_OP_PROG4        8'h12
`define FSRG_OP_QPROG        8'h32
`define FSRG_OP_QPROG4       8'h34
`define FSRG_OP_ERASE        8'h20

// frame bit counts
`define FSRG_OPCODE_BITS     6'd8
`define FSRG_ADDR_END        6'd32

// register byte offsets
`define FSRG_REG_CTRL        8'h00
`define FSRG_REG_STATUS1     8'h04
`define FSRG_REG_STATUS2     8'h08
`define FSRG_REG_EVENT       8'h0C
`define FSRG_REG_MASK        8'h10
`define FSRG_REG_LAST_CMD    8'h14

// field positions
`define FSRG_CTRL_QE         0
`define FSRG_CTRL_FOUR       1
`define FSRG_ST1_WIP         0
`define FSRG_ST1_WEL         1
`define FSRG_ST2_PSUS        0
`define FSRG_ST2_ESUS        1
`define FSRG_ST2_PERR        5
`define FSRG_EV_WIDTH        5
`define FSRG_EV_DONE         0
`define FSRG_EV_REJECT       1
`define FSRG_EV_PERR         2
`define FSRG_EV_RES_IGN      3
`define FSRG_EV_UNDEF_RD     4
`define FSRG_LAST_ACC        8

`endif

// ==== fsrg_pkg.sv ====
// fsrg_pkg.sv: types of the suspend/resume gate
// assumes fsrg_params.svh in the include path
`include "fsrg_params.svh"
package fsrg_pkg;
	typedef enum logic [2:0]
	{
		FSRG_IDLE   = 3'b000,
		FSRG_PROG   = 3'b001,
		FSRG_ERASE  = 3'b010,
		FSRG_PSUSP  = 3'b011,
		FSRG_ESUSP  = 3'b100,
		FSRG_NPROG  = 3'b101,
		FSRG_NPSUSP = 3'b110
	} fsrg_state_type;
endpackage

// ==== fsrg_gate_assertions.sv ====
// fsrg_gate_assertions.sv: port-level checks of the suspend/resume gate
// assumes binding to fsrg_gate; all checks in the pclk domain
`timescale 1ns/1ps
`default_nettype none
`include "fsrg_params.svh"

module fsrg_gate_assertions
(
	// clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// apb
	input wire logic [7:0]  paddr,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] prdata,
	input wire logic        pslverr,
	// core side
	input wire logic        cmd_valid,
	input wire logic [7:0]  cmd_opcode,
	input wire logic        write_in_progress,
	input wire logic        program_suspended_flag,
	input wire logic        erase_suspended_flag,
	input wire logic        irq
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire acc = psel && penable;
	wire rd_acc = acc && !pwrite;
	wire any_susp = program_suspended_flag || erase_suspended_flag;
	wire resume_seen = cmd_valid && cmd_opcode == `FSRG_OP_RESUME;
	// state moves on the same edge that raises the pulse; depth 2 reaches back before that edge
	a_cmd_one_cycle: assert property (cmd_valid |=> !cmd_valid)
		else $error("cmd_valid held longer than one cycle");
	a_resume_runs: assert property (resume_seen && $past(any_susp, 2) |-> write_in_progress)
		else $error("resume did not restart the suspended operation");
	a_resume_ignored: assert property (resume_seen && !$past(any_susp, 2)
		&& !$past(write_in_progress, 2) |-> !write_in_progress && !any_susp)
		else $error("resume with nothing suspended changed state");
	a_psus_needs_resume: assert property ($fell(program_suspended_flag) |-> ##[0:2] resume_seen)
		else $error("program suspend left without resume");
	a_psus_idle: assert property (program_suspended_flag |-> !write_in_progress)
		else $error("busy while program suspended");
	a_err_unmapped: assert property (acc |-> pslverr == (paddr > `FSRG_REG_LAST_CMD
		|| paddr[1:0] != 2'h0))
		else $error("pslverr wrong for address");
	a_st2_flags: assert property (rd_acc && paddr == `FSRG_REG_STATUS2
		|-> prdata[1:0] == $past({erase_suspended_flag, program_suspended_flag}))
		else $error("status2 suspend bits differ from flags");
	a_st1_busy: assert property (rd_acc && paddr == `FSRG_REG_STATUS1
		|-> prdata[0] == $past(write_in_progress))
		else $error("status1 busy bit differs from pin");
	a_irq_sticky: assert property ($fell(irq) |-> $past(acc && pwrite
		&& (paddr == `FSRG_REG_EVENT || paddr == `FSRG_REG_MASK)))
		else $error("irq dropped without event or mask write");
endmodule

bind fsrg_gate fsrg_gate_assertions u_chk
(
	.pclk(pclk),
	.presetn(presetn),
	.paddr(paddr),
	.psel(psel),
	.penable(penable),
	.pwrite(pwrite),
	.prdata(prdata),
	.pslverr(pslverr),
	.cmd_valid(cmd_valid),
	.cmd_opcode(cmd_opcode),
	.write_in_progress(write_in_progress),
	.program_suspended_flag(program_suspended_flag),
	.erase_suspended_flag(erase_suspended_flag),
	.irq(irq)
);
`default_nettype wire

// ==== fsrg_host_model.sv ====
// fsrg_host_model.sv: behavioural spi and four-line host framing opcodes
// assumes the bench calls frame(); link clock stands still between frames
`timescale 1ns/1ps
`default_nettype none

module fsrg_host_model
(
	// link pins
	output logic       cs_n,
	output logic       sck,
	output logic [3:0] io_in
);
	localparam int HALF_NS = 80;
	initial
	begin
		cs_n = 1'b1;
		sck = 1'b0;
		io_in = 4'h0;
	end
	// opcode then optional 24-bit address, msb first, high nibble first
	task automatic frame(input logic [7:0] op, input logic [23:0] addr,
		input logic has_addr, input logic quad);
		logic [31:0] bits;
		int i;
		int n;
		bits = {op, addr};
		n = has_addr ? 32 : 8;
		#3 cs_n = 1'b0;
		for (i = 0; i < n; i += quad ? 4 : 1)
		begin
			// unused lanes toggle so nothing reads as a stable level
			io_in = quad ? bits[31-i -: 4] : {~io_in[3:1], bits[31-i]};
			#HALF_NS sck = 1'b1;
			#HALF_NS sck = 1'b0;
		end
		#HALF_NS cs_n = 1'b1;
		io_in = ~io_in;
		// idle gap also spaces a resume from the next suspend
		#(4*HALF_NS);
	endtask
endmodule
`default_nettype wire

// ==== tb_top.sv ====
// tb_top.sv: self-checking bench of the suspend/resume gate
// assumes fsrg_host_model drives the link pins; apb master lives here
`timescale 1ns/1ps
`default_nettype none
`include "fsrg_params.svh"

module tb_top;
	typedef struct packed
	{
		logic [7:0] op;
		logic [1:0] allow;
	} fsrg_row_type;
	// suspend opcode is arbitrary, must match the dut parameter
	localparam logic [7:0] SUS = 8'hB0;
	// allow: bit1 in erase suspend, bit0 in program suspend
	fsrg_row_type rows [18] = '{
		'{8'h0B, 2'h3}, '{8'h3B, 2'h3}, '{8'hBB, 2'h3}, '{8'h6B, 2'h3}, '{8'hEB, 2'h3},
		'{8'hED, 2'h3}, '{8'h3D, 2'h3}, '{8'hE1, 2'h3}, '{8'h39, 2'h3}, '{8'hFF, 2'h3},
		'{8'h48, 2'h3}, '{8'h42, 2'h2}, '{8'h01, 2'h0}, '{8'h20, 2'h0}, '{8'h02, 2'h2},
		'{8'h30, 2'h3}, '{8'h04, 2'h3}, '{8'h06, 2'h3}};
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        cs_n;
	logic        sck;
	logic [3:0]  io_in;
	logic        cmd_valid;
	logic [7:0]  cmd_opcode;
	logic        write_in_progress;
	logic        program_suspended_flag;
	logic        erase_suspended_flag;
	logic        irq;
	int          n_valid = 0;
	logic        quad = 1'b0;
	logic        slv;
	logic [31:0] q;
	int          err_count = 0;
	int          n_checks = 0;

	always #5 pclk = ~pclk;

	fsrg_host_model u_host (.cs_n(cs_n), .sck(sck), .io_in(io_in));
	fsrg_gate #(.SUSPEND_OPCODE(SUS), .PROG_CYCLES(400), .ERASE_CYCLES(800)) u_dut
	(
		.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .cs_n(cs_n), .sck(sck), .io_in(io_in), .cmd_valid(cmd_valid),
		.cmd_opcode(cmd_opcode), .write_in_progress(write_in_progress),
		.program_suspended_flag(program_suspended_flag),
		.erase_suspended_flag(erase_suspended_flag), .irq(irq)
	);

	// accepted opcodes counted as one-cycle pulses
	always @(posedge pclk)
		if (cmd_valid === 1'b1)
			n_valid++;

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic check(input string s, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", s, exp, seen);
		end
	endtask

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		for (n = 1; pready !== 1'b1 && n < 20; n++)
			@(posedge pclk);
		if (pready !== 1'b1)
		begin
			check("pready", {31'h0, pready}, 32'h1);
			tally_and_finish();
		end
		q = prdata;
		slv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rdc(input string s, input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		check(s, q, e);
	endtask

	// pins packed as busy, program suspended, erase suspended, irq
	task automatic pins(input string s, input logic [3:0] e);
		repeat (2) @(posedge pclk);
		#1;
		check(s, {28'h0, write_in_progress, program_suspended_flag,
			erase_suspended_flag, irq}, {28'h0, e});
	endtask

	task automatic send(input logic [7:0] op, input logic [23:0] a = 24'h0);
		u_host.frame(op, a, a != 24'h0, quad);
	endtask

	task automatic wait_idle();
		int n;
		for (n = 0; write_in_progress !== 1'b0 && n < 2000; n++)
			@(posedge pclk);
		if (write_in_progress !== 1'b0)
		begin
			check("busy timeout", 32'h1, 32'h0);
			tally_and_finish();
		end
	endtask

	task automatic run_rows(input int col);
		int i;
		int v;
		for (i = 0; i < 18; i++)
		begin
			v = n_valid;
			send(rows[i].op);
			check("cmd_valid", n_valid - v, {31'h0, rows[i].allow[col]});
			check("cmd_opcode", {24'h0, cmd_opcode}, {24'h0, rows[i].op});
			rdc("last_cmd", `FSRG_REG_LAST_CMD, {23'h0, rows[i].allow[col], rows[i].op});
		end
	endtask

	initial
	begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		pins("reset pins", 4'h0);
		rdc("ctrl", `FSRG_REG_CTRL, 32'h0);
		rdc("status2", `FSRG_REG_STATUS2, 32'h0);
		rdc("unmapped", 8'h18, 32'h0);
		check("slverr", {31'h0, slv}, 32'h1);
		$display("test reset done");
		apb(1'b1, `FSRG_REG_CTRL, 32'h1);
		send(`FSRG_OP_WR_EN);
		send(`FSRG_OP_PROG, 24'h001000);
		pins("prog run", 4'h8);
		send(SUS);
		pins("prog susp", 4'h4);
		run_rows(0);
		apb(1'b1, `FSRG_REG_CTRL, 32'h0);
		rdc("ctrl locked", `FSRG_REG_CTRL, 32'h1);
		send(`FSRG_OP_RESUME);
		pins("resume", 4'h8);
		wait_idle();
		rdc("status2 done", `FSRG_REG_STATUS2, 32'h0);
		rdc("event done", `FSRG_REG_EVENT, 32'h3);
		apb(1'b1, `FSRG_REG_EVENT, 32'h1F);
		apb(1'b1, `FSRG_REG_MASK, 32'h1F);
		send(`FSRG_OP_RESUME);
		pins("resume ignored", 4'h1);
		rdc("event ignored", `FSRG_REG_EVENT, 32'h8);
		apb(1'b1, `FSRG_REG_MASK, 32'h0);
		pins("masked", 4'h0);
		apb(1'b1, `FSRG_REG_MASK, 32'h8);
		pins("unmasked", 4'h1);
		apb(1'b1, `FSRG_REG_EVENT, 32'h8);
		pins("cleared", 4'h0);
		$display("test program suspend done");
		send(`FSRG_OP_WR_EN);
		send(`FSRG_OP_ERASE, 24'h002000);
		send(SUS);
		pins("erase susp", 4'h2);
		run_rows(1);
		send(`FSRG_OP_FAST_READ, 24'h002010);
		apb(1'b0, `FSRG_REG_EVENT, 32'h0);
		check("undef read", q & 32'h10, 32'h10);
		send(`FSRG_OP_WR_EN);
		send(`FSRG_OP_PROG, 24'h002100);
		rdc("prog error", `FSRG_REG_STATUS2, 32'h22);
		send(`FSRG_OP_CLR_STAT);
		rdc("clear status", `FSRG_REG_STATUS2, 32'h2);
		send(`FSRG_OP_WR_EN);
		send(`FSRG_OP_PROG, 24'h005000);
		wait_idle();
		pins("nested done", 4'h2);
		send(`FSRG_OP_WR_EN);
		send(`FSRG_OP_PROG, 24'h006000);
		send(SUS);
		pins("both susp", 4'h6);
		send(`FSRG_OP_WR_EN);
		send(`FSRG_OP_PROG, 24'h007000);
		rdc("second prog", `FSRG_REG_LAST_CMD, 32'h2);
		send(`FSRG_OP_RESUME);
		wait_idle();
		pins("back to erase susp", 4'h2);
		send(`FSRG_OP_RESUME);
		wait_idle();
		pins("erase done", 4'h0);
		$display("test erase suspend done");
		// four-line mode without quad enable: quad reads must be refused in suspend
		apb(1'b1, `FSRG_REG_CTRL, 32'h2);
		quad = 1'b1;
		send(`FSRG_OP_WR_EN);
		send(`FSRG_OP_PROG, 24'h003000);
		send(SUS);
		pins("quad susp", 4'h4);
		send(`FSRG_OP_QUAD_OUT);
		rdc("quad read no qe", `FSRG_REG_LAST_CMD, 32'h06B);
		send(`FSRG_OP_RESUME);
		pins("quad resume", 4'h8);
		wait_idle();
		$display("test four-line done");
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		pins("second reset", 4'h0);
		rdc("ctrl reset", `FSRG_REG_CTRL, 32'h0);
		$display("test second reset done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
